// *** rtl/common_irq_pkg.sv ***
// constants, register map and carrier types of the common interrupt and buffer config bank
package common_irq_pkg;

  // ==========================================================
  // register offsets (byte addresses on the host register port)
  localparam logic [15:0] OFS_INTERRUPT_FLAGS = 16'h0015;
  localparam logic [15:0] OFS_INTERRUPT_ENABLES = 16'h0016;
  localparam logic [15:0] OFS_RETRY_INTERVAL_HI = 16'h0017;
  localparam logic [15:0] OFS_RETRY_INTERVAL_LO = 16'h0018;
  localparam logic [15:0] OFS_RETRY_LIMIT = 16'h0019;
  localparam logic [15:0] OFS_RX_BUFFER_SIZES = 16'h001A;
  localparam logic [15:0] OFS_TX_BUFFER_SIZES = 16'h001B;
  localparam logic [15:0] OFS_WAKE_EVENT_FLAGS = 16'h0020;
  localparam logic [15:0] OFS_WAKE_EVENT_ENABLES = 16'h0021;
  localparam logic [15:0] OFS_LCP_ECHO_PERIOD = 16'h0028;
  localparam logic [15:0] OFS_PEER_IP_0 = 16'h002A;
  localparam logic [15:0] OFS_PEER_IP_1 = 16'h002B;
  localparam logic [15:0] OFS_PEER_IP_2 = 16'h002C;
  localparam logic [15:0] OFS_PEER_IP_3 = 16'h002D;
  localparam logic [15:0] OFS_PEER_PORT_HI = 16'h002E;
  localparam logic [15:0] OFS_PEER_PORT_LO = 16'h002F;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [15:0] RST_RETRY_INTERVAL = 16'h07D0;
  localparam logic [7:0] RST_RETRY_LIMIT = 8'h08;
  localparam logic [7:0] RST_BUFFER_SIZES = 8'h55;
  localparam logic [7:0] RST_LCP_ECHO_PERIOD = 8'h28;
  localparam logic [31:0] RST_PEER_IP = 32'h0000_0000;
  localparam logic [15:0] RST_PEER_PORT = 16'h0000;
  localparam logic [15:0] RST_PEND_COUNT = 16'h0000;

  // ==========================================================
  // field positions and masks
  localparam int BIT_IP_CLASH = 7;
  localparam int BIT_PORT_UNREACHABLE_FLAG = 6;
  localparam int BIT_PPPOE_END = 5;
  localparam int BIT_WAKE = 0;
  localparam int NUM_SOCKETS = 4;
  localparam logic [7:0] FLAGS_IMPL_MASK = 8'hEF;
  localparam logic [7:0] FLAGS_W1C_MASK = 8'hE0;
  localparam logic [7:0] WAKE_IMPL_MASK = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ==========================================================
  // timing: units of the held values and the pending-delay prescaler
  localparam int RETRY_UNIT_US = 100;
  localparam int LCP_UNIT_MS = 25;
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [1:0] PEND_PRESCALE_LAST = 2'h3;  // decrement every 4 clocks
  localparam logic [15:0] PEND_STEP = 16'h0001;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] retry_interval;
    logic [7:0] retry_limit;
    logic [7:0] rx_buffer_sizes;
    logic [7:0] tx_buffer_sizes;
    logic [7:0] lcp_echo_period;
  } cfg_t;

  typedef struct packed {
    logic [31:0] ip;
    logic [15:0] port;
  } peer_t;

endpackage : common_irq_pkg

// *** rtl/common_irq_and_buffer_config.sv ***
// common interrupt flags, masks, host alert pin and socket buffer/retry configuration
`timescale 1ns/1ns
module common_irq_and_buffer_config (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire common_irq_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic ip_clash_event,
  input wire logic port_unreachable_flag_event,
  input wire common_irq_pkg::peer_t port_unreachable_flag_peer_in,
  input wire logic pppoe_end_event,
  input wire logic pppoe_active,
  input wire logic wake_event,
  input wire logic [31:0] socket_event_reg,
  input wire logic [31:0] socket_retry_count,
  input wire logic pin_alert_enable,
  input wire logic [15:0] pending_delay,
  output logic host_alert_n,
  output common_irq_pkg::cfg_t cfg,
  output common_irq_pkg::peer_t unreachable_peer,
  output logic [15:0] socket_retry_time,
  output logic [3:0] socket_retry_load
);

  // ==========================================================
  // state
  logic [7:0] flags_q, flags_d;
  logic [7:0] enables_q, enables_d;
  logic [7:0] wake_q, wake_d;
  logic [7:0] wake_en_q, wake_en_d;
  common_irq_pkg::cfg_t cfg_q, cfg_d;
  common_irq_pkg::peer_t peer_q, peer_d;
  logic [7:0] rdata_q, rdata_d;
  logic alert_n_q, alert_n_d;
  logic [15:0] pend_q, pend_d;
  logic [1:0] pre_q, pre_d;
  logic [3:0] load_q, load_d;
  logic [3:0] sock_pending;
  logic wr_hit_flags, wr_hit_wake;
  logic alert_cond;

  // per-socket pending summary and retry reload request
  genvar gi;
  generate
    for (gi = 0; gi < common_irq_pkg::NUM_SOCKETS; gi++) begin : g_sock
      assign sock_pending[gi] = |socket_event_reg[gi*8 +: 8];
      assign load_d[gi] = (socket_retry_count[gi*8 +: 8] == common_irq_pkg::BYTE_ZERO);
    end
  endgenerate

  assign wr_hit_flags = reg_req.wr && (reg_req.addr == common_irq_pkg::OFS_INTERRUPT_FLAGS);
  assign wr_hit_wake = reg_req.wr && (reg_req.addr == common_irq_pkg::OFS_WAKE_EVENT_FLAGS);

  // ==========================================================
  // flag registers: set beats a same-cycle write-one clear
  always_comb begin
    flags_d = flags_q;
    wake_d = wake_q;
    peer_d = peer_q;
    if (wr_hit_flags) begin
      flags_d = flags_q & ~(reg_req.wdata & common_irq_pkg::FLAGS_W1C_MASK);
    end
    if (wr_hit_wake) begin
      wake_d = wake_q & ~(reg_req.wdata & common_irq_pkg::WAKE_IMPL_MASK);
    end
    if (ip_clash_event) begin
      flags_d[common_irq_pkg::BIT_IP_CLASH] = 1'b1;
    end
    if (port_unreachable_flag_event) begin
      flags_d[common_irq_pkg::BIT_PORT_UNREACHABLE_FLAG] = 1'b1;
      peer_d = port_unreachable_flag_peer_in;
    end
    if (pppoe_end_event && pppoe_active) begin
      flags_d[common_irq_pkg::BIT_PPPOE_END] = 1'b1;
    end
    if (wake_event) begin
      wake_d[common_irq_pkg::BIT_WAKE] = 1'b1;
    end
    // socket bits follow their own event registers, host writes have no effect
    flags_d[common_irq_pkg::NUM_SOCKETS-1:0] = sock_pending;
    flags_d = flags_d & common_irq_pkg::FLAGS_IMPL_MASK;
    wake_d = wake_d & common_irq_pkg::WAKE_IMPL_MASK;
  end

  // ==========================================================
  // plain read/write configuration
  always_comb begin
    enables_d = enables_q;
    wake_en_d = wake_en_q;
    cfg_d = cfg_q;
    if (reg_req.wr) begin
      if (reg_req.addr == common_irq_pkg::OFS_INTERRUPT_ENABLES) begin
        enables_d = reg_req.wdata & common_irq_pkg::FLAGS_IMPL_MASK;
      end else if (reg_req.addr == common_irq_pkg::OFS_WAKE_EVENT_ENABLES) begin
        wake_en_d = reg_req.wdata & common_irq_pkg::WAKE_IMPL_MASK;
      end else if (reg_req.addr == common_irq_pkg::OFS_RETRY_INTERVAL_HI) begin
        cfg_d.retry_interval[15:8] = reg_req.wdata;
      end else if (reg_req.addr == common_irq_pkg::OFS_RETRY_INTERVAL_LO) begin
        cfg_d.retry_interval[7:0] = reg_req.wdata;
      end else if (reg_req.addr == common_irq_pkg::OFS_RETRY_LIMIT) begin
        cfg_d.retry_limit = reg_req.wdata;
      end else if (reg_req.addr == common_irq_pkg::OFS_RX_BUFFER_SIZES) begin
        cfg_d.rx_buffer_sizes = reg_req.wdata;
      end else if (reg_req.addr == common_irq_pkg::OFS_TX_BUFFER_SIZES) begin
        cfg_d.tx_buffer_sizes = reg_req.wdata;
      end else if (reg_req.addr == common_irq_pkg::OFS_LCP_ECHO_PERIOD) begin
        cfg_d.lcp_echo_period = reg_req.wdata;
      end
    end
  end

  // ==========================================================
  // read mux, registered; unmapped offsets read zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_req.rd) begin
      if (reg_req.addr == common_irq_pkg::OFS_INTERRUPT_FLAGS) begin
        rdata_d = flags_q;
      end else if (reg_req.addr == common_irq_pkg::OFS_INTERRUPT_ENABLES) begin
        rdata_d = enables_q;
      end else if (reg_req.addr == common_irq_pkg::OFS_RETRY_INTERVAL_HI) begin
        rdata_d = cfg_q.retry_interval[15:8];
      end else if (reg_req.addr == common_irq_pkg::OFS_RETRY_INTERVAL_LO) begin
        rdata_d = cfg_q.retry_interval[7:0];
      end else if (reg_req.addr == common_irq_pkg::OFS_RETRY_LIMIT) begin
        rdata_d = cfg_q.retry_limit;
      end else if (reg_req.addr == common_irq_pkg::OFS_RX_BUFFER_SIZES) begin
        rdata_d = cfg_q.rx_buffer_sizes;
      end else if (reg_req.addr == common_irq_pkg::OFS_TX_BUFFER_SIZES) begin
        rdata_d = cfg_q.tx_buffer_sizes;
      end else if (reg_req.addr == common_irq_pkg::OFS_WAKE_EVENT_FLAGS) begin
        rdata_d = wake_q;
      end else if (reg_req.addr == common_irq_pkg::OFS_WAKE_EVENT_ENABLES) begin
        rdata_d = wake_en_q;
      end else if (reg_req.addr == common_irq_pkg::OFS_LCP_ECHO_PERIOD) begin
        rdata_d = cfg_q.lcp_echo_period;
      end else if (reg_req.addr == common_irq_pkg::OFS_PEER_IP_0) begin
        rdata_d = peer_q.ip[31:24];
      end else if (reg_req.addr == common_irq_pkg::OFS_PEER_IP_1) begin
        rdata_d = peer_q.ip[23:16];
      end else if (reg_req.addr == common_irq_pkg::OFS_PEER_IP_2) begin
        rdata_d = peer_q.ip[15:8];
      end else if (reg_req.addr == common_irq_pkg::OFS_PEER_IP_3) begin
        rdata_d = peer_q.ip[7:0];
      end else if (reg_req.addr == common_irq_pkg::OFS_PEER_PORT_HI) begin
        rdata_d = peer_q.port[15:8];
      end else if (reg_req.addr == common_irq_pkg::OFS_PEER_PORT_LO) begin
        rdata_d = peer_q.port[7:0];
      end else begin
        rdata_d = common_irq_pkg::BYTE_ZERO;
      end
    end
  end

  // ==========================================================
  // host alert pin with pending-delay holdoff
  // the condition uses registered flags, so the pin lags an event by two clocks
  assign alert_cond = (|(flags_q & enables_q)) || (|(wake_q & wake_en_q));

  always_comb begin
    pend_d = pend_q;
    pre_d = pre_q;
    alert_n_d = alert_n_q;
    if (!alert_n_q) begin
      // pin is low: release as soon as the cause or its enable goes away
      if (!alert_cond || !pin_alert_enable) begin
        alert_n_d = 1'b1;
        pend_d = pending_delay;
        pre_d = 2'h0;
      end
    end else begin
      if (pend_q != common_irq_pkg::RST_PEND_COUNT) begin
        pre_d = pre_q + 2'h1;
        if (pre_q == common_irq_pkg::PEND_PRESCALE_LAST) begin
          pend_d = pend_q - common_irq_pkg::PEND_STEP;
        end
      end
      if (alert_cond && pin_alert_enable && (pend_q == common_irq_pkg::RST_PEND_COUNT)) begin
        alert_n_d = 1'b0;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= common_irq_pkg::RST_FLAGS;
      enables_q <= common_irq_pkg::RST_ENABLES;
      wake_q <= common_irq_pkg::RST_FLAGS;
      wake_en_q <= common_irq_pkg::RST_ENABLES;
      cfg_q.retry_interval <= common_irq_pkg::RST_RETRY_INTERVAL;
      cfg_q.retry_limit <= common_irq_pkg::RST_RETRY_LIMIT;
      cfg_q.rx_buffer_sizes <= common_irq_pkg::RST_BUFFER_SIZES;
      cfg_q.tx_buffer_sizes <= common_irq_pkg::RST_BUFFER_SIZES;
      cfg_q.lcp_echo_period <= common_irq_pkg::RST_LCP_ECHO_PERIOD;
      peer_q.ip <= common_irq_pkg::RST_PEER_IP;
      peer_q.port <= common_irq_pkg::RST_PEER_PORT;
      rdata_q <= common_irq_pkg::BYTE_ZERO;
      alert_n_q <= 1'b1;
      pend_q <= common_irq_pkg::RST_PEND_COUNT;
      pre_q <= 2'h0;
      load_q <= 4'h0;
    end else begin
      flags_q <= flags_d;
      enables_q <= enables_d;
      wake_q <= wake_d;
      wake_en_q <= wake_en_d;
      cfg_q <= cfg_d;
      peer_q <= peer_d;
      rdata_q <= rdata_d;
      alert_n_q <= alert_n_d;
      pend_q <= pend_d;
      pre_q <= pre_d;
      load_q <= load_d;
    end
  end

  // outputs straight from flops; socket retry seed is the interval register itself
  assign reg_rdata = rdata_q;
  assign host_alert_n = alert_n_q;
  assign cfg = cfg_q;
  assign unreachable_peer = peer_q;
  assign socket_retry_time = cfg_q.retry_interval;
  assign socket_retry_load = load_q;

endmodule : common_irq_and_buffer_config

// *** tb/common_irq_chk.sv ***
// assertion checker for the common interrupt and buffer config bank
`timescale 1ns/1ns
module common_irq_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire common_irq_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic ip_clash_event,
  input wire logic port_unreachable_flag_event,
  input wire common_irq_pkg::peer_t port_unreachable_flag_peer_in,
  input wire logic pin_alert_enable,
  input wire logic [15:0] pending_delay,
  input wire logic [31:0] socket_retry_count,
  input wire logic host_alert_n,
  input wire common_irq_pkg::cfg_t cfg,
  input wire common_irq_pkg::peer_t unreachable_peer,
  input wire logic [15:0] socket_retry_time,
  input wire logic [3:0] socket_retry_load
);
  // ==========================================================
  // single clock domain: clocking and reset declared once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  clash_read_a: assert property (ip_clash_event ##1 (reg_req.rd && reg_req.addr == 16'h0015)
    |=> reg_rdata[7]) else $error("clash flag missing on read");
  rsvd_bit_a: assert property (reg_req.rd && reg_req.addr == 16'h0015 |=> !reg_rdata[4])
    else $error("reserved flag bit reads one");
  peer_capture_a: assert property (port_unreachable_flag_event |=> unreachable_peer == $past(port_unreachable_flag_peer_in))
    else $error("peer not captured");
  pin_off_a: assert property (!host_alert_n |-> $past(pin_alert_enable))
    else $error("alert low while pin disabled");
  // a delay of 2 keeps the pin high for at least 8 clocks after release
  holdoff_a: assert property ($rose(host_alert_n) && pending_delay == 16'h0002 |-> host_alert_n [*8])
    else $error("alert reasserted inside hold-off");
  retry_seed_a: assert property ($stable(cfg.retry_interval) |-> socket_retry_time == cfg.retry_interval)
    else $error("socket retry time differs");
  retry_load_a: assert property (socket_retry_count[7:0] == 8'h00 |=> socket_retry_load[0])
    else $error("retry load missing");
  lcp_write_a: assert property (reg_req.wr && reg_req.addr == 16'h0028
    |=> cfg.lcp_echo_period == $past(reg_req.wdata)) else $error("echo period not written");
endmodule : common_irq_chk

bind common_irq_and_buffer_config common_irq_chk common_irq_chk_inst (.ref_clk, .rst_n, .reg_req,
  .reg_rdata, .ip_clash_event, .port_unreachable_flag_event, .port_unreachable_flag_peer_in, .pin_alert_enable, .pending_delay,
  .socket_retry_count, .host_alert_n, .cfg, .unreachable_peer, .socket_retry_time,
  .socket_retry_load);

// *** tb/testbench.sv ***
// self-checking testbench for the common interrupt and buffer config bank
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  common_irq_pkg::reg_req_t req = '0;
  logic [7:0] rdata;
  logic [3:0] ev = 4'h0;  // clash, unreachable, pppoe end, wake
  common_irq_pkg::peer_t peer_in = 48'hC0A8_0015_0BB8;
  logic pppoe_on = 1'b0;
  logic [31:0] sock_ev = 32'h0000_0000;
  logic [31:0] sock_cnt = 32'h0101_0101;
  logic pin_en = 1'b0;
  logic alert_n;
  common_irq_pkg::cfg_t cfg;
  common_irq_pkg::peer_t peer;
  logic [15:0] rtime;
  logic [3:0] rload;
  int mismatches = 0;
  int checked = 0;
  int n;

  common_irq_and_buffer_config common_irq_and_buffer_config_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .ip_clash_event(ev[3]),
    .port_unreachable_flag_event(ev[2]), .port_unreachable_flag_peer_in(peer_in), .pppoe_end_event(ev[1]),
    .pppoe_active(pppoe_on), .wake_event(ev[0]), .socket_event_reg(sock_ev),
    .socket_retry_count(sock_cnt), .pin_alert_enable(pin_en), .pending_delay(16'h0002),
    .host_alert_n(alert_n), .cfg(cfg), .unreachable_peer(peer), .socket_retry_time(rtime),
    .socket_retry_load(rload));

  // ==========================================================
  // clock and common tasks
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // one host access; strobes drop a clock later so back-to-back calls never collide
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge ref_clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge ref_clk);
    req = '0;
    q = rdata;
  endtask : acc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask : wr

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    check($sformatf("read %h", a), {40'h0, q}, {40'h0, exp});
  endtask : rchk

  task automatic pulse(input int i);
    @(negedge ref_clk);
    ev[i] = 1'b1;
    @(negedge ref_clk);
    ev[i] = 1'b0;
  endtask : pulse

  // bounded wait for the alert pin; a hang ends the run
  task automatic wait_pin(input logic lvl, output int c);
    c = 0;
    while (alert_n !== lvl) begin
      @(negedge ref_clk);
      c++;
      if (c > 40) begin
        mismatches++;
        end_of_test();
      end
    end
  endtask : wait_pin

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [15:0] a [10] = '{16'h0015, 16'h0016, 16'h0017, 16'h0018, 16'h0019, 16'h001A,
                            16'h001B, 16'h0020, 16'h0021, 16'h0028};
    logic [7:0] e [10] = '{8'h00, 8'h00, 8'h07, 8'hD0, 8'h08, 8'h55, 8'h55, 8'h00, 8'h00, 8'h28};
    for (int i = 0; i < 10; i++) begin
      rchk(a[i], e[i]);
    end
    check("cfg", cfg, 48'h07D0_0855_5528);
    check("retry time", {32'h0, rtime}, 48'h0000_0000_07D0);
  endtask : t_reset

  // code 11 cannot appear: with four sockets it would break the 8 KB total
  task automatic t_config();
    wr(16'h0017, 8'h13);
    wr(16'h0018, 8'h88);
    wr(16'h0019, 8'hFF);
    wr(16'h001A, 8'h06);
    wr(16'h001B, 8'h15);
    wr(16'h0028, 8'hC8);
    check("cfg", cfg, 48'h1388_FF06_15C8);
    wr(16'h0016, 8'hFF);
    rchk(16'h0016, 8'hEF);
    wr(16'h0021, 8'hFF);
    rchk(16'h0021, 8'h01);
    wr(16'h0022, 8'h5A);
    rchk(16'h0022, 8'h00);
    wr(16'h0016, 8'h00);
    wr(16'h0021, 8'h00);
    check("retry time", {32'h0, rtime}, 48'h0000_0000_1388);
  endtask : t_config

  task automatic t_events();
    fork
      pulse(3);
      begin
        @(negedge ref_clk);
        rchk(16'h0015, 8'h80);
      end
    join
    pulse(1);
    rchk(16'h0015, 8'h80);
    pppoe_on = 1'b1;
    pulse(1);
    pulse(2);
    rchk(16'h0015, 8'hE0);
    check("peer", peer, 48'hC0A8_0015_0BB8);
    rchk(16'h002A, 8'hC0);
    rchk(16'h002F, 8'hB8);
    wr(16'h0015, 8'h5F);
    rchk(16'h0015, 8'hA0);
    wr(16'h0015, 8'hA0);
    rchk(16'h0015, 8'h00);
    pulse(0);
    rchk(16'h0020, 8'h01);
    wr(16'h0020, 8'hFF);
    rchk(16'h0020, 8'h00);
  endtask : t_events

  task automatic t_socket();
    @(negedge ref_clk);
    sock_ev[23:16] = 8'h01;
    sock_cnt[7:0] = 8'h00;
    rchk(16'h0015, 8'h04);
    check("retry load", {44'h0, rload}, 48'h1);
    sock_ev[23:16] = 8'h00;
    sock_cnt[7:0] = 8'h01;
    // the socket bit has already followed its register down by the time a read is taken
    rchk(16'h0015, 8'h00);
    rchk(16'h0015, 8'h00);
    check("retry load", {44'h0, rload}, 48'h0);
  endtask : t_socket

  task automatic t_alert();
    @(negedge ref_clk);
    pin_en = 1'b1;
    sock_ev[23:16] = 8'h02;
    repeat (6) @(negedge ref_clk);
    check("masked pin", {47'h0, alert_n}, 48'h1);
    wr(16'h0016, 8'h04);
    wait_pin(1'b0, n);
    check("alert delay", {47'h0, n <= 3}, 48'h1);
    pin_en = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("disabled pin", {47'h0, alert_n}, 48'h1);
    pin_en = 1'b1;
    wait_pin(1'b0, n);
    check("hold-off", {47'h0, n >= 6 && n <= 14}, 48'h1);
    wr(16'h0016, 8'h00);
    wait_pin(1'b1, n);
    check("mask release", {47'h0, n <= 3}, 48'h1);
    wr(16'h0016, 8'h04);
    wait_pin(1'b0, n);
    sock_ev[23:16] = 8'h00;
    wait_pin(1'b1, n);
    check("flag release", {47'h0, n <= 3}, 48'h1);
    wr(16'h0021, 8'h01);
    pulse(0);
    wait_pin(1'b0, n);
    wr(16'h0020, 8'h01);
    wait_pin(1'b1, n);
    check("wake release", {47'h0, n <= 3}, 48'h1);
  endtask : t_alert

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_config();
    t_events();
    t_socket();
    t_alert();
    end_of_test();
  end
endmodule : testbench
